// *** design/sfce_engine.v ***
// Function
// R1: With protect enable set and protect pin low, enable bit cannot be cleared.
// R2: Latch clear makes all blocks and the status register unwritable.
// R3: Latch set, enable set, pin low: only unlocked blocks writable, status locked.
// R4: Host selects, sends read opcode and three address bytes; data returns MSB first.
// R5: Only the low sixteen address bits select a byte.
// R6: Serial input ignored after the read address for the rest of the read.
// R7: Read address increments per byte and wraps from top to zero.
// R8: Host sets the latch in its own select cycle before programming.
// R9: Program cycle starts when select rises after the last data bit.
// R10: During a write cycle only read-status works; busy bit reads one.
// R11: Program writes 1 to 128 bytes in one page, wrapping within the page.
// R12: Excess data overwrites earlier buffered bytes; unsupplied bytes stay unchanged.
// R13: No program into a locked sector; only unprotected targets accepted.
// R14: Host must erase a sector before reprogramming any byte in it.
// R15: Latch clears when the program cycle completes.
// R16: Write command with latch clear is ignored until a new select fall.
// R17: Sector erase chooses the sector from address bit fifteen.
// R18: Sector erase clears every byte of an unlocked sector, self-timed.
// R19: Latch clears when sector erase completes.
// R20: Chip erase clears both sectors when nothing is locked.
// R21: Chip erase lasts about two seconds and clears the latch after.
// R22: All fields shift MSB first; commands start on select falling edge.
// R23: Opcodes decoded with bit three ignored.
// R24: Status bit one is latch, bit seven protect enable; all ones while busy.
// R25: Latch is clear after reset.
// R26: Busy durations are parameters so simulation can shorten them.
`include "sfce_defs.vh"
module sfce_engine #(
   parameter [31:0] PROG_CYCLES  = `SFCE_PROG_CYC,
   parameter [31:0] SECT_CYCLES  = `SFCE_SECT_CYC,
   parameter [31:0] CHIP_CYCLES  = `SFCE_CHIP_CYC
) (
   input  wire       clock,
   input  wire       reset,
   input  wire       select_n,
   input  wire       sclk,
   input  wire       sdi,
   input  wire       write_protect_n,
   input  wire       block_lock_bit,
   input  wire       hw_protect_enable,
   input  wire       hw_protect_clear,
   output reg        sdo,
   output reg        sdo_oe_n,
   output reg        busy,
   output reg        write_latch,
   output reg        hw_protect_enable_q
);
   // One-hot frame states: idle, opcode, address, read data, program data,
   // status out, ignore the rest of the frame
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_OPC  = 7'h02;
   localparam [6:0] S_ADR  = 7'h04;
   localparam [6:0] S_RD   = 7'h08;
   localparam [6:0] S_PGM  = 7'h10;
   localparam [6:0] S_STS  = 7'h20;
   localparam [6:0] S_IGN  = 7'h40;

   // Kind of self-timed cycle in flight
   localparam [1:0] W_NONE = 2'd0;
   localparam [1:0] W_PROG = 2'd1;
   localparam [1:0] W_SECT = 2'd2;
   localparam [1:0] W_CHIP = 2'd3;

   wire       sel_n_s;
   wire       sclk_s;
   wire       sdi_s;
   wire       wp_n_s;
   wire       sel_a_s;
   wire       wp_a_s;
   reg  [7:0] status;
   reg        sel_n_d1_q;
   reg        sclk_d1_q;
   reg [6:0]  state_q;
   reg [7:0]  shift_q;
   reg [2:0]  bit_q;
   reg [1:0]  byte_q;
   reg [7:0]  opcode_q;
   reg [15:0] addr_q;
   reg [7:0]  out_q;
   reg [7:0]  mem_q [0:65535];
   reg [7:0]  page_q [0:127];
   reg [127:0] page_vld_q;
   reg        pending_q;
   reg [1:0]  wkind_q;
   reg [31:0] timer_q;
   reg [16:0] erase_idx_q;
   reg        hwpen_q;
   integer    i;

   // Select and protect pins pass the synchroniser inverted, so its reset
   // value reads as deselected and unprotected; otherwise a false select
   // edge would follow every reset
   sfce_sync2 u_sync_sel (
      .clock (clock),
      .reset (reset),
      .d     (~select_n),
      .q     (sel_a_s)
   );
   sfce_sync2 u_sync_sclk (
      .clock (clock),
      .reset (reset),
      .d     (sclk),
      .q     (sclk_s)
   );
   sfce_sync2 u_sync_sdi (
      .clock (clock),
      .reset (reset),
      .d     (sdi),
      .q     (sdi_s)
   );
   sfce_sync2 u_sync_wp (
      .clock (clock),
      .reset (reset),
      .d     (~write_protect_n),
      .q     (wp_a_s)
   );
   assign sel_n_s = ~sel_a_s;
   assign wp_n_s  = ~wp_a_s;

   wire sel_fall = sel_n_d1_q & ~sel_n_s;
   wire sel_rise = ~sel_n_d1_q & sel_n_s;
   wire sclk_rise = ~sclk_d1_q & sclk_s;
   wire sclk_fall = sclk_d1_q & ~sclk_s;
   wire [7:0] rx_byte = {shift_q[6:0], sdi_s};
   wire [7:0] op_m = rx_byte & `SFCE_OP_MASK; // R23
   wire hw_prot = hwpen_q & ~wp_n_s;
   // Locked sectors are never writable, whatever the latch
   wire array_ok = write_latch & ~block_lock_bit; // R2 R3 R13
   wire status_ok = write_latch & ~hw_prot; // R2 R3
   // Whole byte received on this rising serial clock
   wire byte_done = !sel_n_s && sclk_rise && (bit_q == 3'd7);
   // Last cycle of a self-timed write: the array update lands here
   wire wr_done = busy && (timer_q <= 32'd1);

   // Busy forces every bit high, so a polling host needs only one flag
   always @* begin
      status = 8'hff; // R24
      if (!busy) begin
         status                 = 8'h00;
         status[`SFCE_ST_HWPEN] = hwpen_q;
         status[`SFCE_ST_LOCK]  = block_lock_bit;
         status[`SFCE_ST_LATCH] = write_latch;
         status[`SFCE_ST_BUSY]  = 1'b0;
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         sel_n_d1_q <= 1'b1;
         sclk_d1_q  <= 1'b0;
      end else begin
         sel_n_d1_q <= sel_n_s;
         sclk_d1_q  <= sclk_s;
      end
   end

   // Protect enable: external config, clear refused under hardware protection
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         hwpen_q             <= 1'b0;
         hw_protect_enable_q <= 1'b0;
      end else begin
         if (hw_protect_enable && status_ok && !busy)
            hwpen_q <= 1'b1;
         else if (hw_protect_clear && status_ok && !busy && !hw_prot) // R1
            hwpen_q <= 1'b0;
         hw_protect_enable_q <= hwpen_q;
      end
   end

   // Serial front end
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q   <= S_IDLE;
         shift_q   <= 8'h00;
         bit_q     <= 3'd0;
         byte_q    <= 2'd0;
         opcode_q  <= 8'h00;
         addr_q    <= 16'h0000;
         out_q     <= 8'h00;
         sdo       <= 1'b0;
         sdo_oe_n  <= 1'b1;
         pending_q <= 1'b0;
         wkind_q   <= W_NONE;
         page_vld_q <= 128'd0;
         write_latch <= 1'b0; // R25
         busy      <= 1'b0;
         timer_q   <= 32'd0;
         erase_idx_q <= 17'd0;
      end else begin
         if (sel_n_s) begin
            sdo_oe_n <= 1'b1;
         end
         if (sel_fall) begin // R22
            state_q  <= S_OPC;
            bit_q    <= 3'd0;
            byte_q   <= 2'd0;
            pending_q <= 1'b0;
         end else if (sel_rise) begin
            state_q <= S_IDLE;
            // Program starts only on select rising at a byte boundary
            if (state_q == S_PGM && pending_q && bit_q == 3'd0 && !busy) begin // R9
               busy    <= 1'b1;
               wkind_q <= W_PROG;
               timer_q <= PROG_CYCLES;
            end
         end else if (!sel_n_s && sclk_rise) begin
            shift_q <= rx_byte;
            bit_q   <= bit_q + 3'd1;
            case (state_q)
               S_OPC: begin
                  if (bit_q == 3'd7) begin
                     opcode_q <= op_m;
                     if (busy && op_m != `SFCE_OP_RD_STATUS)
                        state_q <= S_IGN; // R10
                     else begin
                        case (op_m)
                           `SFCE_OP_SET_LATCH: begin
                              write_latch <= 1'b1;
                              state_q <= S_IGN;
                           end
                           `SFCE_OP_CLR_LATCH: begin
                              write_latch <= 1'b0;
                              state_q <= S_IGN;
                           end
                           `SFCE_OP_RD_STATUS: begin
                              out_q   <= status;
                              state_q <= S_STS;
                           end
                           `SFCE_OP_READ: state_q <= S_ADR;
                           `SFCE_OP_PROGRAM, `SFCE_OP_SEC_ERASE,
                           `SFCE_OP_CHIP_ERASE: begin
                              state_q <= write_latch ? S_ADR : S_IGN; // R16
                              if (op_m == `SFCE_OP_CHIP_ERASE && write_latch) begin
                                 state_q <= S_IGN;
                                 if (array_ok) begin // R20
                                    busy <= 1'b1;
                                    wkind_q <= W_CHIP;
                                    timer_q <= CHIP_CYCLES; // R21
                                    erase_idx_q <= 17'd0;
                                 end
                              end
                           end
                           default: state_q <= S_IGN;
                        endcase
                     end
                  end
               end
               S_ADR: begin
                  if (bit_q == 3'd7) begin
                     byte_q <= byte_q + 2'd1;
                     if (byte_q == 2'd1)
                        addr_q[15:8] <= rx_byte; // R5
                     if (byte_q == 2'd2) begin
                        addr_q[7:0] <= rx_byte;
                        if (opcode_q == `SFCE_OP_READ) begin
                           state_q <= S_RD; // R6
                           out_q   <= mem_q[{addr_q[15:8], rx_byte}]; // R4
                        end else if (opcode_q == `SFCE_OP_PROGRAM) begin
                           state_q <= array_ok ? S_PGM : S_IGN; // R13
                           page_vld_q <= 128'd0;
                        end else begin
                           state_q <= S_IGN;
                           if (array_ok) begin // R18
                              busy <= 1'b1;
                              wkind_q <= W_SECT;
                              timer_q <= SECT_CYCLES;
                              erase_idx_q <= {1'b0, addr_q[15], 15'd0}; // R17
                           end
                        end
                     end
                  end
               end
               S_PGM: begin
                  if (bit_q == 3'd7) begin
                     page_vld_q[addr_q[6:0]] <= 1'b1; // R12
                     pending_q <= 1'b1;
                     addr_q[6:0] <= addr_q[6:0] + 7'd1; // R11
                  end
               end
               default: ;
            endcase
         end else if (!sel_n_s && sclk_fall) begin
            // Shift out on falling edge so the host samples on rising
            if (state_q == S_RD || state_q == S_STS) begin
               sdo_oe_n <= 1'b0;
               sdo      <= out_q[7 - bit_q]; // R22
               if (bit_q == 3'd0 && byte_q == 2'd3 && state_q == S_RD) begin
                  // bit_q wraps to 0 after the last rising edge of a byte
               end
            end
         end
         // Reload read data at each completed byte
         if (!sel_n_s && sclk_rise && bit_q == 3'd7) begin
            if (state_q == S_RD) begin
               addr_q <= addr_q + 16'd1; // R7
               out_q  <= mem_q[addr_q + 16'd1];
            end else if (state_q == S_STS) begin
               out_q <= status;
            end
         end
         if (busy) begin
            if (timer_q <= 32'd1) begin
               busy        <= 1'b0;
               write_latch <= 1'b0; // R15 R19 R21
            end else begin
               timer_q <= timer_q - 32'd1;
            end
         end
      end
   end

   // Page buffer takes each whole byte of a program frame
   always @(posedge clock) begin
      if (byte_done && state_q == S_PGM) begin
         page_q[addr_q[6:0]] <= rx_byte; // R11
      end
   end

   // Array update; the array holds no reset, like flash cells.
   // Program only clears bits, and only bytes marked in page_vld_q are written, so unsupplied bytes keep their contents
   always @(posedge clock) begin
      if (wr_done) begin
         if (wkind_q == W_PROG) begin
            for (i = 0; i < 128; i = i + 1) begin
               if (page_vld_q[i]) begin // R12
                  mem_q[{addr_q[15:7], i[6:0]}] <= mem_q[{addr_q[15:7], i[6:0]}] & page_q[i];
               end
            end
         end else if (wkind_q == W_SECT) begin
            for (i = 0; i < 32768; i = i + 1) begin
               mem_q[{erase_idx_q[15], i[14:0]}] <= `SFCE_ERASED; // R18
            end
         end else if (wkind_q == W_CHIP) begin
            for (i = 0; i < 65536; i = i + 1) begin
               mem_q[i[15:0]] <= `SFCE_ERASED; // R20
            end
         end
      end
   end
endmodule

// *** design/sfce_defs.vh ***
`ifndef SFCE_DEFS_VH
`define SFCE_DEFS_VH
`define SFCE_CLK_MHZ        100
`define SFCE_OP_SET_LATCH   8'h06
`define SFCE_OP_CLR_LATCH   8'h04
`define SFCE_OP_RD_STATUS   8'h05
`define SFCE_OP_READ        8'h03
`define SFCE_OP_PROGRAM     8'h02
`define SFCE_OP_SEC_ERASE   8'h52
`define SFCE_OP_CHIP_ERASE  8'h62
`define SFCE_OP_MASK        8'hf7
`define SFCE_ST_BUSY        0
`define SFCE_ST_LATCH       1
`define SFCE_ST_LOCK        2
`define SFCE_ST_HWPEN       7
`define SFCE_PAGE_MSB       6
`define SFCE_SECTOR_BIT     15
`define SFCE_ERASED         8'hff
`define SFCE_PROG_US        75
`define SFCE_SECT_MS        1000
`define SFCE_CHIP_MS        2000
`define SFCE_PROG_CYC       (`SFCE_PROG_US * `SFCE_CLK_MHZ)
`define SFCE_SECT_CYC       (`SFCE_SECT_MS * 1000 * `SFCE_CLK_MHZ)
`define SFCE_CHIP_CYC       (`SFCE_CHIP_MS * 1000 * `SFCE_CLK_MHZ)
`endif

// *** design/sfce_sync2.v ***
module sfce_sync2 (
   input  wire clock,
   input  wire reset,
   input  wire d,
   output reg  q
);
   reg meta_q;
   // First stage feeds only the second
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// *** verif/sfce_engine_checker.sv ***
module sfce_engine_checker #(
   parameter [31:0] PROG_CYCLES = 32'h0000_0190,
   parameter [31:0] CHIP_CYCLES = 32'h0000_0258
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic select_n,
   input wire logic sclk,
   input wire logic write_protect_n,
   input wire logic block_lock_bit,
   input wire logic sdo,
   input wire logic sdo_oe_n,
   input wire logic busy,
   input wire logic write_latch,
   input wire logic hw_protect_enable_q
);
   default clocking dc @(posedge clock); endclocking
   default disable iff (reset);
   logic [31:0] busy_len_q;
   // Length of the current busy spell, so the self-timed bounds need no long repetition
   always_ff @(posedge clock or posedge reset)
      if (reset)
         busy_len_q <= 32'h0000_0000;
      else
         busy_len_q <= busy ? busy_len_q + 32'h0000_0001 : 32'h0000_0000;
   AST_LATCH_DROP: assert property ($fell(busy) |-> ##[0:2] !write_latch)
      else $error("write latch still set after write cycle");
   AST_BUSY_NEEDS_LATCH: assert property ($rose(busy) |-> $past(write_latch))
      else $error("write cycle started without latch");
   AST_BUSY_UNLOCKED: assert property ($rose(busy) |-> !block_lock_bit)
      else $error("write cycle started on locked array");
   AST_BUSY_MIN: assert property ($fell(busy) |-> busy_len_q + 32'h0000_0002 >= PROG_CYCLES)
      else $error("write cycle too short");
   AST_BUSY_MAX: assert property (busy_len_q <= CHIP_CYCLES + 32'h0000_0004)
      else $error("write cycle too long");
   AST_HWPEN_HELD: assert property (hw_protect_enable_q && !write_protect_n |=> hw_protect_enable_q)
      else $error("protect enable cleared while pin low");
   AST_HWPEN_SET: assert property ($rose(hw_protect_enable_q) |-> $past(write_latch))
      else $error("protect enable set without latch");
   AST_SDO_RELEASED: assert property (select_n [*6] |-> sdo_oe_n)
      else $error("serial output driven while deselected");
   AST_SDO_STEADY: assert property (sclk [*5] |-> $stable(sdo))
      else $error("serial output moved while clock high");
   cover property ($fell(busy));
   cover property (!sdo_oe_n ##1 sdo_oe_n);
   cover property (hw_protect_enable_q && !write_protect_n);
endmodule

bind sfce_engine sfce_engine_checker #(.PROG_CYCLES(PROG_CYCLES), .CHIP_CYCLES(CHIP_CYCLES))
   i_sfce_engine_checker (.clock(clock), .reset(reset), .select_n(select_n), .sclk(sclk),
   .write_protect_n(write_protect_n), .block_lock_bit(block_lock_bit), .sdo(sdo),
   .sdo_oe_n(sdo_oe_n), .busy(busy), .write_latch(write_latch),
   .hw_protect_enable_q(hw_protect_enable_q));

// *** verif/sfce_host.sv ***
module sfce_host (
   input  wire logic clock,
   input  wire logic sdo,
   output logic      select_n,
   output logic      sclk,
   output logic      sdi
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      select_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Select moves only with sclk low; sclk stands still outside frames
   task automatic frame(input logic on);
      tick(8);
      select_n <= !on;
      tick(8);
   endtask
   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sdi <= tx[i];
         tick(8);
         sclk <= 1'b1;
         rx[i] = sdo;
         tick(8);
         sclk <= 1'b0;
      end
   endtask
endmodule

// *** verif/sfce_engine_tb_top.sv ***
module sfce_engine_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic write_protect_n = 1'b1;
   logic block_lock_bit = 1'b0;
   logic hw_protect_enable = 1'b0;
   logic hw_protect_clear = 1'b0;
   wire  select_n, sclk, sdi, sdo, sdo_oe_n, busy, write_latch, hw_protect_enable_q;
   localparam logic [31:0] PROG_CYC = 32'h0000_0190;
   localparam logic [31:0] SECT_CYC = 32'h0000_01f4;
   localparam logic [31:0] CHIP_CYC = 32'h0000_0258;
   int   n_errors = 0;
   int   n_checks = 0;
   always #5 clock = ~clock;
   sfce_engine #(.PROG_CYCLES(PROG_CYC), .SECT_CYCLES(SECT_CYC),
      .CHIP_CYCLES(CHIP_CYC)) i_sfce_engine (.clock(clock), .reset(reset),
      .select_n(select_n), .sclk(sclk), .sdi(sdi), .write_protect_n(write_protect_n),
      .block_lock_bit(block_lock_bit), .hw_protect_enable(hw_protect_enable),
      .hw_protect_clear(hw_protect_clear), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .busy(busy),
      .write_latch(write_latch), .hw_protect_enable_q(hw_protect_enable_q));
   sfce_host i_sfce_host (.clock(clock), .sdo(sdo), .select_n(select_n), .sclk(sclk),
      .sdi(sdi));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] b;
      rx = {};
      i_sfce_host.frame(1'b1);
      foreach (tx[i]) begin
         i_sfce_host.xbyte(tx[i], b);
         rx.push_back(b);
      end
      i_sfce_host.frame(1'b0);
   endtask
   task automatic op(input logic [7:0] q[$]);
      logic [7:0] r[$];
      xfer(q, r);
   endtask
   task automatic st(input logic [7:0] exp);
      logic [7:0] r[$];
      xfer({8'h05, 8'h00}, r);
      chk(r[1], exp);
   endtask
   // Polls status a bounded number of times so a stuck busy cannot hang the run
   task automatic settle();
      logic [7:0] r[$];
      for (int i = 0; i < 20; i++) begin
         xfer({8'h05, 8'h00}, r);
         if (r[1][0] === 1'b0)
            return;
      end
      chk(r[1], 8'h00);
   endtask
   task automatic rd(input logic [23:0] a, input logic [7:0] exp[$]);
      logic [7:0] tx[$];
      logic [7:0] r[$];
      tx = {8'h03, a[23:16], a[15:8], a[7:0]};
      foreach (exp[i]) tx.push_back(8'h06);
      xfer(tx, r);
      foreach (exp[i]) chk(r[i + 4], exp[i]);
      chk({7'h00, sdo_oe_n}, 8'h01);
   endtask
   task automatic t_basic();
      st(8'h00);
      op({8'h0e});
      st(8'h02);
      op({8'h0c});
      st(8'h00);
      op({8'h06});
      op({8'h62});
      st(8'hff);
      settle();
      st(8'h00);
      rd(24'h00_7fff, {8'hff, 8'hff});
      $display("test basic done");
   endtask
   task automatic t_program();
      op({8'h06});
      op({8'h02, 8'h12, 8'h00, 8'h7f, 8'ha5, 8'h3c});
      chk({7'h00, busy}, 8'h01);
      st(8'hff);
      settle();
      st(8'h00);
      rd(24'h34_007e, {8'hff, 8'ha5, 8'hff});
      rd(24'h5a_ffff, {8'hff, 8'h3c});
      st(8'h00);
      op({8'h06});
      op({8'h02, 8'h00, 8'h80, 8'h00, 8'h11});
      settle();
      op({8'h06});
      op({8'h52, 8'h00, 8'hc1, 8'h23});
      settle();
      st(8'h00);
      rd(24'h00_8000, {8'hff});
      rd(24'h00_007f, {8'ha5});
      $display("test program done");
   endtask
   task automatic t_guard();
      op({8'h02, 8'h00, 8'h01, 8'h00, 8'h00});
      chk({7'h00, busy}, 8'h00);
      rd(24'h00_0100, {8'hff});
      block_lock_bit <= 1'b1;
      op({8'h06});
      op({8'h02, 8'h00, 8'h01, 8'h00, 8'h00});
      chk({7'h00, busy}, 8'h00);
      op({8'h04});
      block_lock_bit <= 1'b0;
      rd(24'h00_0100, {8'hff});
      $display("test guard done");
   endtask
   task automatic t_protect();
      op({8'h06});
      hw_protect_enable <= 1'b1;
      repeat (4) @(posedge clock);
      hw_protect_enable <= 1'b0;
      write_protect_n <= 1'b0;
      // Let the pin pass its synchroniser before the clear request
      repeat (4) @(posedge clock);
      hw_protect_clear <= 1'b1;
      repeat (8) @(posedge clock);
      chk({7'h00, hw_protect_enable_q}, 8'h01);
      write_protect_n <= 1'b1;
      repeat (8) @(posedge clock);
      chk({7'h00, hw_protect_enable_q}, 8'h00);
      hw_protect_clear <= 1'b0;
      $display("test protect done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      t_basic();
      t_program();
      t_guard();
      t_protect();
      close_out();
   end
   initial begin
      #400_000;
      n_errors++;
      close_out();
   end
endmodule
